// [core/cxs_exception_seq.sv]
// Exception sequencer: prioritise, acquire vector, stack, load new counter
`timescale 1ns/1ps
module cxs_exception_seq import cxs_pkg::*; #(
  parameter int ADDR_W = CXS_ADDR_W,
  parameter int SR_W = CXS_SR_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [CXS_LVL_W-1:0] irq_level_pin,
  input wire cxs_src_s src,
  input wire logic insn_boundary,
  input wire logic reset_insn,
  input wire logic [SR_W-1:0] sr_in,
  input wire logic [ADDR_W-1:0] next_pc,
  input wire cxs_ack_s ack,
  input wire logic push_done,
  input wire logic fetch_done,
  output cxs_bus_s bus,
  output logic abort,
  output logic busy,
  output logic resume,
  output logic [SR_W-1:0] sr_out,
  output logic [SR_W-1:0] sr_saved,
  output logic [ADDR_W-1:0] stacked_pc,
  output logic [CXS_VEC_W-1:0] vector,
  output logic reset_line
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] vec_to_addr(input logic [CXS_VEC_W-1:0] v);
    vec_to_addr = ADDR_W'(v) << CXS_VEC_SCALE_SHIFT;
  endfunction : vec_to_addr

  function automatic logic [CXS_VEC_W-1:0] kind_vector(input cxs_kind_e k,
                                                      input logic [3:0] tn);
    case (k)
      CXS_KIND_RESET: kind_vector = CXS_VEC_RESET;
      CXS_KIND_ADDR_ERR: kind_vector = CXS_VEC_ADDR_ERR;
      CXS_KIND_BUS_ERR: kind_vector = CXS_VEC_BUS_ERR;
      CXS_KIND_TRACE: kind_vector = CXS_VEC_TRACE;
      CXS_KIND_ILLEGAL: kind_vector = CXS_VEC_ILLEGAL;
      CXS_KIND_PRIV: kind_vector = CXS_VEC_PRIV;
      CXS_KIND_TRAP: kind_vector = CXS_VEC_TRAP_BASE + {4'h0, tn};
      CXS_KIND_OVERFLOW: kind_vector = CXS_VEC_OVERFLOW;
      CXS_KIND_BOUNDS: kind_vector = CXS_VEC_BOUNDS;
      CXS_KIND_ZERO_DIV: kind_vector = CXS_VEC_ZERO_DIV;
      default: kind_vector = CXS_VEC_SPURIOUS;
    endcase
  endfunction : kind_vector

  function automatic logic is_group0(input cxs_kind_e k);
    is_group0 = (k == CXS_KIND_ADDR_ERR) || (k == CXS_KIND_BUS_ERR);
  endfunction : is_group0

  // Boot status: supervisor, trace off, mask seven
  localparam logic [SR_W-1:0] SR_BOOT = (SR_W'(1) << CXS_SR_S) |
    (SR_W'(CXS_LVL_MAX) << CXS_SR_MASK_LO);

  // ---------------------------------------------------------------
  // Interrupt detection
  // ---------------------------------------------------------------
  logic irq_pending;
  logic [CXS_LVL_W-1:0] irq_level;
  logic nmi_take;
  logic [CXS_LVL_W-1:0] cur_mask;

  cxs_irq_detect #(.LVL_W(CXS_LVL_W)) u_irq (
    .ref_clk(ref_clk),
    .reset(reset),
    .irq_level_pin(irq_level_pin),
    .mask(cur_mask),
    .nmi_take(nmi_take),
    .pending(irq_pending),
    .pending_level(irq_level)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cxs_state_e state, next_state;
  cxs_kind_e kind, next_kind;
  logic [CXS_VEC_W-1:0] next_vector;
  logic [SR_W-1:0] next_sr_out, next_sr_saved;
  logic [ADDR_W-1:0] next_stacked_pc;
  logic [CXS_LVL_W-1:0] ack_lvl, next_ack_lvl;
  logic trace_after, next_trace_after;
  logic boot, next_boot;
  logic reset_line_q, next_reset_line;
  logic [1:0] abort_cnt, next_abort_cnt;
  logic g0_req;
  cxs_kind_e g0_kind, g12_kind;

  assign cur_mask = sr_out[CXS_SR_MASK_LO +: CXS_LVL_W];

  // ---------------------------------------------------------------
  // Priority
  // ---------------------------------------------------------------

  // Group zero: address error above bus error
  always_comb begin
    g0_req = src.addr_err || src.bus_err;
    g0_kind = src.addr_err ? CXS_KIND_ADDR_ERR : CXS_KIND_BUS_ERR;
  end

  // Between-instruction choice; group two only from the instruction itself
  always_comb begin
    if (src.trap) begin
      g12_kind = CXS_KIND_TRAP;
    end else if (src.overflow) begin
      g12_kind = CXS_KIND_OVERFLOW;
    end else if (src.bounds) begin
      g12_kind = CXS_KIND_BOUNDS;
    end else if (src.zero_div) begin
      g12_kind = CXS_KIND_ZERO_DIV;
    end else if (src.trace || trace_after) begin
      g12_kind = CXS_KIND_TRACE;
    end else if (irq_pending) begin
      g12_kind = CXS_KIND_IRQ;
    end else if (src.illegal) begin
      g12_kind = CXS_KIND_ILLEGAL;
    end else if (src.priv) begin
      g12_kind = CXS_KIND_PRIV;
    end else begin
      g12_kind = CXS_KIND_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  // Group zero may cut into any step except its own; boot outranks all
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_vector = vector;
    next_sr_out = sr_out;
    next_sr_saved = sr_saved;
    next_stacked_pc = stacked_pc;
    next_ack_lvl = ack_lvl;
    next_trace_after = trace_after;
    next_boot = 1'b0;
    next_reset_line = reset_insn;
    next_abort_cnt = (abort_cnt != 2'h0) ? abort_cnt - 2'h1 : 2'h0;
    nmi_take = 1'b0;
    if (boot) begin
      // Reset: no stacking, four-word vector in program space
      next_kind = CXS_KIND_RESET;
      next_vector = CXS_VEC_RESET;
      next_state = CXS_ST_FETCH;
    end else if (g0_req && !(is_group0(kind) && state != CXS_ST_RUN)) begin
      // Abort anything but a group zero sequence, even a trap in flight; double faults not handled here
      next_kind = g0_kind;
      next_sr_saved = sr_in;
      next_sr_out = sr_in;
      next_sr_out[CXS_SR_S] = 1'b1;
      next_sr_out[CXS_SR_T] = 1'b0;
      next_vector = kind_vector(g0_kind, src.trap_num);
      next_stacked_pc = next_pc;
      next_abort_cnt = CXS_ABORT_CYCLES;
      next_trace_after = 1'b0;
      next_state = CXS_ST_STACK;
    end else begin
      case (state)
        CXS_ST_RUN: begin
          // Status mirrors the core; the mask compare lags one cycle
          next_sr_out = sr_in;
          if (insn_boundary && g12_kind != CXS_KIND_NONE) begin
            next_kind = g12_kind;
            next_sr_saved = sr_in;
            next_sr_out[CXS_SR_S] = 1'b1;
            next_sr_out[CXS_SR_T] = 1'b0;
            next_stacked_pc = next_pc;
            next_vector = kind_vector(g12_kind, src.trap_num);
            // Trace still owed after a group two trap of a traced insn
            next_trace_after = src.trace && (g12_kind >= CXS_KIND_TRAP);
            if (g12_kind == CXS_KIND_TRACE) begin
              next_trace_after = 1'b0;
            end
            if (g12_kind == CXS_KIND_IRQ) begin
              next_ack_lvl = irq_level;
              next_sr_out[CXS_SR_MASK_LO +: CXS_LVL_W] = irq_level;
              nmi_take = 1'b1;
              next_state = CXS_ST_ACK;
            end else begin
              next_state = CXS_ST_STACK;
            end
          end
        end
        CXS_ST_ACK: begin
          if (ack.done) begin
            // Bus error first: nobody answered, so no vector to trust
            if (ack.bus_err) begin
              next_vector = CXS_VEC_SPURIOUS;
            end else if (ack.autovector_request) begin
              next_vector = CXS_VEC_AUTO_BASE + {5'h0, ack_lvl};
            end else begin
              next_vector = ack.vector;
            end
            next_state = CXS_ST_STACK;
          end
        end
        CXS_ST_STACK: begin
          if (push_done) begin
            next_state = CXS_ST_FETCH;
          end
        end
        CXS_ST_FETCH: begin
          if (fetch_done) begin
            next_state = CXS_ST_RESUME;
          end
        end
        CXS_ST_RESUME: begin
          next_state = CXS_ST_RUN;
          next_kind = CXS_KIND_NONE;
        end
        default: next_state = CXS_ST_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // Supervisor, trace off, mask seven
      state <= CXS_ST_RUN;
      kind <= CXS_KIND_RESET;
      vector <= CXS_VEC_RESET;
      sr_out <= SR_BOOT;
      sr_saved <= '0;
      stacked_pc <= '0;
      ack_lvl <= CXS_LVL_NONE;
      trace_after <= 1'b0;
      boot <= 1'b1;
      reset_line_q <= 1'b0;
      abort_cnt <= 2'h0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      vector <= next_vector;
      sr_out <= next_sr_out;
      sr_saved <= next_sr_saved;
      stacked_pc <= next_stacked_pc;
      ack_lvl <= next_ack_lvl;
      trace_after <= next_trace_after;
      boot <= next_boot;
      reset_line_q <= next_reset_line;
      abort_cnt <= next_abort_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    bus = '0;
    bus.ack_req = (state == CXS_ST_ACK);
    bus.ack_level = ack_lvl;
    bus.push_req = (state == CXS_ST_STACK);
    bus.long_frame = is_group0(kind);
    bus.push_words = is_group0(kind) ? CXS_WORDS_LONG_FRAME : CXS_WORDS_SHORT_FRAME;
    bus.fetch_req = (state == CXS_ST_FETCH);
    bus.prog_space = (kind == CXS_KIND_RESET);
    bus.fetch_words = (kind == CXS_KIND_RESET) ? CXS_WORDS_RESET_VEC : CXS_WORDS_VEC;
    bus.vec_addr = vec_to_addr(vector);
  end

  assign abort = (abort_cnt != 2'h0);
  assign busy = (state != CXS_ST_RUN) || boot;
  assign resume = (state == CXS_ST_RESUME);
  assign reset_line = reset_line_q;

endmodule : cxs_exception_seq

// [core/cxs_pkg.sv]
// Package: constants, enums and carrier structs of the exception sequencer
package cxs_pkg;

  // ---------------------------------------------------------------
  // Vector numbers and widths
  // ---------------------------------------------------------------
  localparam int CXS_VEC_W = 8;
  localparam int CXS_ADDR_W = 24;
  localparam int CXS_LVL_W = 3;
  localparam int CXS_SR_W = 16;
  localparam logic [7:0] CXS_VEC_RESET = 8'h00;
  localparam logic [7:0] CXS_VEC_BUS_ERR = 8'h02;
  localparam logic [7:0] CXS_VEC_ADDR_ERR = 8'h03;
  localparam logic [7:0] CXS_VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] CXS_VEC_ZERO_DIV = 8'h05;
  localparam logic [7:0] CXS_VEC_BOUNDS = 8'h06;
  localparam logic [7:0] CXS_VEC_OVERFLOW = 8'h07;
  localparam logic [7:0] CXS_VEC_PRIV = 8'h08;
  localparam logic [7:0] CXS_VEC_TRACE = 8'h09;
  localparam logic [7:0] CXS_VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] CXS_VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] CXS_VEC_TRAP_BASE = 8'h20;
  localparam logic [1:0] CXS_VEC_SCALE_SHIFT = 2'h2;
  localparam logic [2:0] CXS_LVL_MAX = 3'h7;
  localparam logic [2:0] CXS_LVL_NONE = 3'h0;
  localparam logic [3:0] CXS_WORDS_VEC = 4'h2;
  localparam logic [3:0] CXS_WORDS_RESET_VEC = 4'h4;
  localparam logic [3:0] CXS_WORDS_SHORT_FRAME = 4'h3;
  localparam logic [3:0] CXS_WORDS_LONG_FRAME = 4'h7;
  localparam logic [1:0] CXS_ABORT_CYCLES = 2'h2;
  // Status bit positions
  localparam int CXS_SR_T = 15;
  localparam int CXS_SR_S = 13;
  localparam int CXS_SR_MASK_LO = 8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CXS_KIND_NONE = 4'h0,
    CXS_KIND_RESET = 4'h1,
    CXS_KIND_ADDR_ERR = 4'h2,
    CXS_KIND_BUS_ERR = 4'h3,
    CXS_KIND_TRACE = 4'h4,
    CXS_KIND_IRQ = 4'h5,
    CXS_KIND_ILLEGAL = 4'h6,
    CXS_KIND_PRIV = 4'h7,
    CXS_KIND_TRAP = 4'h8,
    CXS_KIND_OVERFLOW = 4'h9,
    CXS_KIND_BOUNDS = 4'ha,
    CXS_KIND_ZERO_DIV = 4'hb
  } cxs_kind_e;

  typedef enum logic [2:0] {
    CXS_ST_RUN = 3'h0,
    CXS_ST_ACK = 3'h1,
    CXS_ST_STACK = 3'h2,
    CXS_ST_FETCH = 3'h3,
    CXS_ST_RESUME = 3'h4
  } cxs_state_e;

  // Exception sources presented by the core
  typedef struct packed {
    logic addr_err;
    logic bus_err;
    logic trace;
    logic illegal;
    logic priv;
    logic trap;
    logic [3:0] trap_num;
    logic overflow;
    logic bounds;
    logic zero_div;
  } cxs_src_s;

  // Request to the core's bus unit
  typedef struct packed {
    logic ack_req;
    logic [2:0] ack_level;
    logic push_req;
    logic long_frame;
    logic [3:0] push_words;
    logic fetch_req;
    logic prog_space;
    logic [3:0] fetch_words;
    logic [23:0] vec_addr;
  } cxs_bus_s;

  // Interrupt acknowledge answer from outside
  typedef struct packed {
    logic done;
    logic autovector_request;
    logic bus_err;
    logic [7:0] vector;
  } cxs_ack_s;

endpackage : cxs_pkg

// [core/cxs_irq_detect.sv]
// Interrupt level synchroniser, pending detection and level seven edge
`timescale 1ns/1ps
module cxs_irq_detect import cxs_pkg::*; #(
  parameter int LVL_W = CXS_LVL_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [LVL_W-1:0] irq_level_pin,
  input wire logic [LVL_W-1:0] mask,
  input wire logic nmi_take,
  output logic pending,
  output logic [LVL_W-1:0] pending_level
);

  // ---------------------------------------------------------------
  // Three stage sampling
  // ---------------------------------------------------------------
  logic [LVL_W-1:0] s1, s2, s3, lvl, next_lvl;
  logic nmi_armed, next_nmi_armed;
  logic nmi_edge, next_nmi_edge;

  always_comb begin
    next_lvl = (s2 == s3) ? s3 : lvl;
    next_nmi_edge = nmi_edge;
    next_nmi_armed = nmi_armed;
    if (lvl != LVL_W'(CXS_LVL_MAX)) begin
      next_nmi_armed = 1'b1;
    end
    // Edge to seven from lower level raises one event each time
    if (nmi_armed && lvl == LVL_W'(CXS_LVL_MAX)) begin
      next_nmi_edge = 1'b1;
      next_nmi_armed = 1'b0;
    end else if (nmi_take) begin
      next_nmi_edge = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
      nmi_armed <= 1'b0;
      nmi_edge <= 1'b0;
    end else begin
      s1 <= irq_level_pin;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
      nmi_armed <= next_nmi_armed;
      nmi_edge <= next_nmi_edge;
    end
  end

  // Level seven passes by edge or when the mask sits below it
  assign pending = (lvl != LVL_W'(CXS_LVL_NONE) && lvl > mask) || nmi_edge;
  assign pending_level = nmi_edge ? LVL_W'(CXS_LVL_MAX) : lvl;

endmodule : cxs_irq_detect

// [tb/cxs_exception_seq_asserts.sv]
// Port checks of the exception sequencer
`timescale 1ns/1ps
module cxs_exception_seq_asserts import cxs_pkg::*; #(
  parameter int ADDR_W = CXS_ADDR_W,
  parameter int SR_W = CXS_SR_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire cxs_src_s src,
  input wire logic reset_insn,
  input wire logic [SR_W-1:0] sr_in,
  input wire cxs_ack_s ack,
  input wire logic fetch_done,
  input wire cxs_bus_s bus,
  input wire logic abort,
  input wire logic busy,
  input wire logic resume,
  input wire logic [SR_W-1:0] sr_out,
  input wire logic [CXS_VEC_W-1:0] vector,
  input wire logic reset_line
);
  // Plain nets so that $past sees a signal
  wire logic [2:0] in_mask = sr_in[CXS_SR_MASK_LO +: 3];
  wire logic [2:0] lvl = bus.ack_level;
  wire logic [7:0] ack_vec = ack.vector;
  wire logic ae = src.addr_err;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // Sequences and properties
  // ------------------------------------------------------------
  sequence s_abort_pulse;
    abort ##1 abort ##1 !abort;
  endsequence
  sequence s_long_push;
    bus.push_req && bus.long_frame && bus.push_words == CXS_WORDS_LONG_FRAME;
  endsequence
  property p_abort;
    (src.bus_err || src.addr_err) && !busy |=> s_abort_pulse;
  endproperty
  property p_g0_stack;
    (src.bus_err || src.addr_err) && !busy |=> s_long_push
      and (vector == ($past(ae) ? CXS_VEC_ADDR_ERR : CXS_VEC_BUS_ERR));
  endproperty
  property p_short_push;
    bus.push_req && !bus.long_frame |-> bus.push_words == CXS_WORDS_SHORT_FRAME;
  endproperty
  property p_fetch;
    bus.fetch_req |-> bus.fetch_words == (bus.prog_space ? CXS_WORDS_RESET_VEC : CXS_WORDS_VEC);
  endproperty
  property p_boot;
    bus.fetch_req && bus.prog_space |-> vector == CXS_VEC_RESET && !bus.push_req
      && sr_out[CXS_SR_S] && !sr_out[CXS_SR_T] && sr_out[10:8] == CXS_LVL_MAX;
  endproperty
  property p_vaddr;
    bus.vec_addr == ADDR_W'({vector, 2'b00});
  endproperty
  property p_ack;
    bus.ack_req |-> sr_out[CXS_SR_S] && !sr_out[CXS_SR_T] && sr_out[10:8] == bus.ack_level;
  endproperty
  property p_mask;
    $rose(bus.ack_req) |-> bus.ack_level > $past(in_mask) || bus.ack_level == CXS_LVL_MAX;
  endproperty
  property p_autovec;
    ack.done && bus.ack_req && ack.autovector_request && !ack.bus_err
      |=> vector == CXS_VEC_AUTO_BASE + 8'($past(lvl));
  endproperty
  property p_spur;
    ack.done && bus.ack_req && ack.bus_err |=> vector == CXS_VEC_SPURIOUS;
  endproperty
  property p_extvec;
    ack.done && bus.ack_req && !ack.autovector_request && !ack.bus_err
      |=> vector == $past(ack_vec);
  endproperty
  property p_resume;
    fetch_done && bus.fetch_req |=> resume ##1 !resume;
  endproperty
  property p_rst_insn;
    reset_insn && !busy |=> reset_line && !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  a_g0_stack: assert property (p_g0_stack) else $error("group zero frame wrong");
  a_short_push: assert property (p_short_push) else $error("short frame size");
  a_fetch: assert property (p_fetch) else $error("vector fetch size");
  a_boot: assert property (p_boot) else $error("boot fetch wrong");
  a_vaddr: assert property (p_vaddr) else $error("vector address wrong");
  a_ack: assert property (p_ack) else $error("status on accept wrong");
  a_mask: assert property (p_mask) else $error("masked level taken");
  a_autovec: assert property (p_autovec) else $error("autovector wrong");
  a_spur: assert property (p_spur) else $error("spurious vector wrong");
  a_extvec: assert property (p_extvec) else $error("fetched vector wrong");
  a_resume: assert property (p_resume) else $error("resume pulse wrong");
  a_rst_insn: assert property (p_rst_insn) else $error("reset line wrong");
endmodule : cxs_exception_seq_asserts

// [tb/cxs_far_model.sv]
// Far-side model: interrupting peripherals and bus control logic
`timescale 1ns/1ps
module cxs_far_model import cxs_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire cxs_bus_s bus,
  input wire logic [1:0] mode,
  input wire logic [7:0] vec,
  input wire logic slow,
  output cxs_ack_s ack,
  output logic push_done,
  output logic fetch_done
);
  // Vector store never written
  localparam logic [7:0] UNINIT_VEC = 8'h0f;
  logic [3:0] cnt;
  logic fire;
  wire logic req = bus.ack_req | bus.push_req | bus.fetch_req;
  // Rearm after each answer so one request gets one pulse
  always @(posedge ref_clk) begin
    if (reset || !req || fire) begin
      cnt <= 4'h0;
      fire <= 1'b0;
    end else if (cnt == (slow ? 4'h9 : 4'h0)) begin
      fire <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  assign push_done = fire && bus.push_req;
  assign fetch_done = fire && bus.fetch_req;
  // Vector lines show the inverse when nobody answers
  assign ack = {fire && bus.ack_req, fire && mode == 2'h1, fire && mode == 2'h2,
    (fire && bus.ack_req) ? (mode == 2'h3 ? UNINIT_VEC : vec) : ~vec};
endmodule : cxs_far_model

// [tb/tb_cpu_exception_sequencer.sv]
// Self-checking bench of the exception sequencer
`timescale 1ns/1ps
module tb_cpu_exception_sequencer import cxs_pkg::*; ;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] irq_level_pin = 3'h0;
  cxs_src_s src = '0;
  logic insn_boundary = 1'b0;
  logic reset_insn = 1'b0;
  logic [15:0] sr_in = 16'h2300;
  logic [23:0] next_pc = 24'h00abc4;
  logic [1:0] mode = 2'h1;
  logic [7:0] vec = 8'h40;
  logic slow = 1'b0;
  cxs_ack_s ack;
  cxs_bus_s bus;
  logic push_done, fetch_done, abort, busy, resume, reset_line;
  logic [15:0] sr_out, sr_saved;
  logic [23:0] stacked_pc;
  logic [7:0] vector;
  int failures = 0;
  int n_compared = 0;
  cxs_exception_seq dut (.ref_clk(ref_clk), .reset(reset), .irq_level_pin(irq_level_pin),
    .src(src), .insn_boundary(insn_boundary), .reset_insn(reset_insn), .sr_in(sr_in),
    .next_pc(next_pc), .ack(ack), .push_done(push_done), .fetch_done(fetch_done), .bus(bus),
    .abort(abort), .busy(busy), .resume(resume), .sr_out(sr_out), .sr_saved(sr_saved),
    .stacked_pc(stacked_pc), .vector(vector), .reset_line(reset_line));
  cxs_far_model far (.ref_clk(ref_clk), .reset(reset), .bus(bus), .mode(mode), .vec(vec),
    .slow(slow), .ack(ack), .push_done(push_done), .fetch_done(fetch_done));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wait_res;
    int i;
    i = 0;
    while (resume !== 1'b1 && i < 300) begin
      @(negedge ref_clk);
      i++;
    end
    if (resume !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask : wait_res
  task automatic strobe(cxs_src_s s, logic b);
    @(posedge ref_clk);
    src <= s;
    insn_boundary <= b;
    @(posedge ref_clk);
    src <= '0;
    insn_boundary <= 1'b0;
  endtask : strobe
  task automatic exc(cxs_src_s s, logic [7:0] e);
    strobe(s, 1'b1);
    wait_res();
    chk("vector", e, vector);
    chk("stacked_pc", next_pc, stacked_pc);
    chk("sr_saved", sr_in, sr_saved);
  endtask : exc
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_grp1;
    cxs_src_s s;
    logic [7:0] ev [8] = '{CXS_VEC_OVERFLOW, CXS_VEC_BOUNDS, CXS_VEC_ZERO_DIV,
      CXS_VEC_ILLEGAL, CXS_VEC_PRIV, CXS_VEC_ILLEGAL, CXS_VEC_TRACE, CXS_VEC_TRAP_BASE + 8'hf};
    for (int i = 0; i < 8; i++) begin
      s = '0;
      slow <= i[0];
      case (i)
        0: s.overflow = 1'b1;
        1: s.bounds = 1'b1;
        2: s.zero_div = 1'b1;
        3: s.illegal = 1'b1;
        4: s.priv = 1'b1;
        5: s = '{illegal: 1'b1, priv: 1'b1, default: '0};
        6: s = '{trace: 1'b1, illegal: 1'b1, default: '0};
        default: s = '{trap: 1'b1, trap_num: 4'hf, default: '0};
      endcase
      exc(s, ev[i]);
    end
    exc('{trace: 1'b1, trap: 1'b1, trap_num: 4'h3, default: '0}, 8'h23);
    exc('0, CXS_VEC_TRACE);
    $display("test group one and two done");
  endtask : t_grp1
  task automatic g0(cxs_src_s s, logic b, logic [7:0] e);
    strobe(s, b);
    wait_res();
    chk("vector", e, vector);
    repeat (3) @(negedge ref_clk);
    chk("busy", 1'b0, busy);
  endtask : g0
  // A zero expected vector means the level must stay masked
  task automatic irq(logic [2:0] l, logic [1:0] m, logic [7:0] e);
    @(posedge ref_clk);
    mode <= m;
    irq_level_pin <= l;
    repeat (5) @(posedge ref_clk);
    if (e == 8'h00) begin
      strobe('0, 1'b1);
      repeat (4) @(negedge ref_clk);
      chk("busy", 1'b0, busy);
    end else begin
      exc('0, e);
    end
    @(posedge ref_clk);
    irq_level_pin <= 3'h0;
    repeat (5) @(posedge ref_clk);
  endtask : irq
  task automatic t_irq;
    for (int l = 1; l < 8; l++) begin
      irq(l[2:0], 2'h1, l > 3 ? CXS_VEC_AUTO_BASE + 8'(l) : 8'h00);
    end
    slow <= 1'b1;
    irq(3'h5, 2'h0, 8'h40);
    irq(3'h6, 2'h2, CXS_VEC_SPURIOUS);
    irq(3'h4, 2'h3, 8'h0f);
    sr_in <= 16'h2700;
    irq(3'h7, 2'h1, CXS_VEC_AUTO_BASE + 8'h7);
    irq_level_pin <= 3'h7;
    repeat (5) @(posedge ref_clk);
    exc('0, CXS_VEC_AUTO_BASE + 8'h7);
    strobe('0, 1'b1);
    repeat (4) @(negedge ref_clk);
    chk("busy", 1'b0, busy);
    @(posedge ref_clk);
    sr_in <= 16'h2300;
    exc('0, CXS_VEC_AUTO_BASE + 8'h7);
    sr_in <= 16'h2300;
    mode <= 2'h1;
    irq_level_pin <= 3'h5;
    repeat (5) @(posedge ref_clk);
    exc('{trace: 1'b1, default: '0}, CXS_VEC_TRACE);
    exc('0, CXS_VEC_AUTO_BASE + 8'h5);
    @(posedge ref_clk);
    irq_level_pin <= 3'h0;
    $display("test interrupts done");
  endtask : t_irq
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("sr_out", 16'h2700, sr_out);
    @(posedge ref_clk);
    reset <= 1'b0;
    wait_res();
    chk("vector", CXS_VEC_RESET, vector);
    chk("sr_out", 16'h2700, sr_out);
    $display("test boot done");
    t_grp1();
    t_irq();
    g0('{bus_err: 1'b1, default: '0}, 1'b0, CXS_VEC_BUS_ERR);
    g0('{bus_err: 1'b1, addr_err: 1'b1, default: '0}, 1'b0, CXS_VEC_ADDR_ERR);
    g0('{bus_err: 1'b1, trap: 1'b1, default: '0}, 1'b1, CXS_VEC_BUS_ERR);
    $display("test group zero done");
    @(posedge ref_clk);
    reset_insn <= 1'b1;
    @(posedge ref_clk);
    reset_insn <= 1'b0;
    @(negedge ref_clk);
    chk("reset_line", 1'b1, reset_line);
    chk("busy", 1'b0, busy);
    $display("test reset instruction done");
    summarize();
  end
endmodule : tb_cpu_exception_sequencer
bind cxs_exception_seq cxs_exception_seq_asserts #(.ADDR_W(ADDR_W), .SR_W(SR_W)) chk_i (
  .ref_clk(ref_clk), .reset(reset), .src(src), .reset_insn(reset_insn), .sr_in(sr_in),
  .ack(ack), .fetch_done(fetch_done), .bus(bus), .abort(abort), .busy(busy), .resume(resume),
  .sr_out(sr_out), .vector(vector), .reset_line(reset_line));
